// ==== pcrc_pkg.sv ====
// package of constants and types for the clock and reset control block
package pcrc_pkg;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [11:0] CLK_SETUP_OFF = 12'h000;
  localparam logic [11:0] RST_STATUS_OFF = 12'h004;
  localparam logic [11:0] RST_CTRL_OFF = 12'h008;
  // ==========================================
  // clock setup field positions
  localparam int DIV_LSB = 0;
  localparam int MUL_LSB = 8;
  localparam int VCO_RANGE_BIT = 16;
  localparam int SRC_LSB = 20;
  // clock setup reset value: divide 1, multiply 1, range 0, raw input
  localparam logic [31:0] CLK_SETUP_RST = 32'h0000_0000;
  localparam logic [7:0] DIV_MAX_CODE = 8'h09;
  // core clock source encodings
  localparam logic [1:0] SRC_RAW = 2'h0;
  localparam logic [1:0] SRC_HALF = 2'h1;
  localparam logic [1:0] SRC_VCO = 2'h3;
  // ==========================================
  // reset status bit positions
  localparam int ST_POR = 0;
  localparam int ST_HARD_EXT = 1;
  localparam int ST_WDOG = 2;
  localparam int ST_BMON = 3;
  localparam int ST_SCAN = 4;
  localparam logic [4:0] RST_STATUS_POR = 5'h01;
  // ==========================================
  // timing: reset hold length in reference cycles
  localparam logic [4:0] RST_HOLD_CYC = 5'h10;
  localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;
  // reset kinds
  typedef enum logic [1:0] {
    PCRC_RUN = 2'b00,
    PCRC_HARD = 2'b01,
    PCRC_SOFT = 2'b11,
    PCRC_POR = 2'b10
  } pcrc_state_t;
  // clock setup fields
  typedef struct packed {
    logic [1:0] src;
    logic vco_range;
    logic [7:0] mul;
    logic [7:0] div;
  } pcrc_setup_t;
  // reset action outputs
  typedef struct packed {
    logic cfg_sample;
    logic loop_reset;
    logic hard_drive;
    logic module_reset;
  } pcrc_act_t;
endpackage

// ==== pcrc_top.sv ====
// clock divider chain, glitch free source mux and reset controller
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - input clock divided by divider plus one
// - loop clock is divided clock times multiplier+1
// - vco is loop, or half when range 0
// - source 11 vco, 01 half vco, else raw
// - overall division one, two or four
// - divider codes 0..9 only, larger clamped
// - status register records latest reset sources
// - power-on resets all and drives hard pin
// - hard pin input starts flow, open drain
// - watchdog expiry starts internal hard reset
// - bus monitor expiry starts internal hard reset
// - scan clamp commands start soft reset
// - only power-on samples config, resets loop
// - every reset clears watchdog, stop, core, peripherals
module pcrc_top (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // board reset pins
  input wire logic power_on_reset_n,
  input wire logic hard_reset_n_in,
  output logic hard_reset_n_out,
  output logic hard_reset_n_oe,
  // internal reset sources
  input wire logic wdog_expired,
  input wire logic bmon_expired,
  input wire logic scan_clamp_active,
  // configuration straps
  input wire logic [7:0] config_pins,
  // reference clock (sampled as a level)
  input wire logic reference_clock_in,
  // clock model outputs
  output logic [15:0] loop_ratio_num,
  output logic [7:0] loop_ratio_den,
  output logic [2:0] core_div_factor,
  output logic core_clock_en,
  output logic [1:0] core_src_active,
  // reset actions
  output logic config_sample,
  output logic loop_reset,
  output logic module_reset,
  output logic [7:0] config_latched
);
  // ==========================================
  // input synchronisers
  logic [1:0] por_sync; // power-on pin
  logic [1:0] hpin_sync; // hard reset pin
  logic [1:0] ref_sync; // reference clock
  logic [15:0] cfg_sync; // strap pins, two stages
  // two flops for every pin input
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      por_sync <= 2'h0;
      hpin_sync <= 2'h3;
      ref_sync <= 2'h0;
      cfg_sync <= 16'h0000;
    end else if (ce) begin
      por_sync <= {por_sync[0], power_on_reset_n};
      hpin_sync <= {hpin_sync[0], hard_reset_n_in};
      ref_sync <= {ref_sync[0], reference_clock_in};
      cfg_sync <= {cfg_sync[7:0], config_pins};
    end
  end
  logic ref_prev; // last synced reference level
  logic hpin_prev; // hard pin level seen last cycle
  // ==========================================
  // bus address phase capture
  logic wr_pend_reg; // write data phase pending
  logic [11:0] addr_reg; // captured offset
  logic take; // valid address phase
  assign take = hsel && hready && htrans[1];
  pcrc_pkg::pcrc_setup_t setup_reg; // clock setup register
  logic [4:0] status_reg; // most recent reset sources
  logic [1:0] wd_en_reg; // watchdog and monitor enables
  // decode of a read or write to given offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction
  // address phase, zero wait state slave
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend_reg <= take && hwrite;
        addr_reg <= take ? haddr[11:0] : addr_reg;
      end
    end
  end
  // read data registered in address phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hrdata <= pcrc_pkg::BUS_ERR_DATA;
    end else if (ce && take && !hwrite) begin
      if (hit(haddr[11:0], pcrc_pkg::CLK_SETUP_OFF)) begin
        hrdata <= {10'h000, setup_reg.src, 3'h0, setup_reg.vco_range, setup_reg.mul, setup_reg.div};
      end else if (hit(haddr[11:0], pcrc_pkg::RST_STATUS_OFF)) begin
        hrdata <= {27'h0, status_reg};
      end else if (hit(haddr[11:0], pcrc_pkg::RST_CTRL_OFF)) begin
        hrdata <= {30'h0, wd_en_reg};
      end else begin
        // unmapped reads zero
        hrdata <= pcrc_pkg::BUS_ERR_DATA;
      end
    end
  end
  // ==========================================
  // reset controller
  pcrc_pkg::pcrc_state_t state_reg; // current reset kind
  logic [4:0] hold_reg; // reference edges still to hold
  logic ref_edge; // rising reference edge
  logic por_req, hard_ext, wd_req, bm_req;
  assign ref_edge = ref_sync[1] && !ref_prev;
  assign por_req = !por_sync[1];
  // own drive excluded: only a falling pin seen while running counts
  assign hard_ext = !hpin_sync[1] && hpin_prev && (state_reg == pcrc_pkg::PCRC_RUN);
  assign wd_req = wdog_expired && wd_en_reg[0];
  assign bm_req = bmon_expired && wd_en_reg[1];
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_prev <= 1'b0;
      hpin_prev <= 1'b1;
    end else if (ce) begin
      ref_prev <= ref_sync[1];
      hpin_prev <= hpin_sync[1];
    end
  end
  // state sequence, power-on wins over hard over soft
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= pcrc_pkg::PCRC_POR;
      hold_reg <= pcrc_pkg::RST_HOLD_CYC;
    end else if (ce) begin
      if (por_req) begin
        state_reg <= pcrc_pkg::PCRC_POR;
        hold_reg <= pcrc_pkg::RST_HOLD_CYC;
      end else if (hard_ext || wd_req || bm_req) begin
        state_reg <= (state_reg == pcrc_pkg::PCRC_POR) ? state_reg : pcrc_pkg::PCRC_HARD;
        hold_reg <= pcrc_pkg::RST_HOLD_CYC;
      end else if (scan_clamp_active && state_reg == pcrc_pkg::PCRC_RUN) begin
        state_reg <= pcrc_pkg::PCRC_SOFT;
        hold_reg <= pcrc_pkg::RST_HOLD_CYC;
      end else if (state_reg != pcrc_pkg::PCRC_RUN) begin
        if (hold_reg == 5'h00) begin
          state_reg <= (state_reg == pcrc_pkg::PCRC_SOFT && scan_clamp_active) ? state_reg : pcrc_pkg::PCRC_RUN;
        end else if (ref_edge) begin
          hold_reg <= hold_reg - 5'h01;
        end
      end
    end
  end
  // latest sources recorded at each new reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_reg <= pcrc_pkg::RST_STATUS_POR;
    end else if (ce) begin
      if (por_req) begin
        status_reg <= pcrc_pkg::RST_STATUS_POR;
      end else if (state_reg == pcrc_pkg::PCRC_RUN && (hard_ext || wd_req || bm_req || scan_clamp_active)) begin
        status_reg <= {scan_clamp_active, bm_req, wd_req, hard_ext, 1'b0};
      end
    end
  end
  // reset actions per kind
  pcrc_pkg::pcrc_act_t act;
  always_comb begin
    act = '0;
    unique case (state_reg)
      pcrc_pkg::PCRC_RUN: act = '0;
      // only power-on samples and resets loop
      pcrc_pkg::PCRC_POR: act = '{cfg_sample: 1'b1, loop_reset: 1'b1, hard_drive: 1'b1, module_reset: 1'b1};
      pcrc_pkg::PCRC_HARD: act = '{cfg_sample: 1'b0, loop_reset: 1'b0, hard_drive: 1'b1, module_reset: 1'b1};
      pcrc_pkg::PCRC_SOFT: act = '{cfg_sample: 1'b0, loop_reset: 1'b0, hard_drive: 1'b0, module_reset: 1'b1};
    endcase
  end
  // registered action outputs, open drain hard pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      config_sample <= 1'b1;
      loop_reset <= 1'b1;
      module_reset <= 1'b1;
      hard_reset_n_oe <= 1'b1;
      hard_reset_n_out <= 1'b0;
      config_latched <= 8'h00;
    end else if (ce) begin
      config_sample <= act.cfg_sample;
      loop_reset <= act.loop_reset;
      module_reset <= act.module_reset;
      hard_reset_n_oe <= act.hard_drive;
      hard_reset_n_out <= 1'b0;
      if (act.cfg_sample) begin
        config_latched <= cfg_sync[15:8];
      end
    end
  end
  // ==========================================
  // register writes
  logic [7:0] div_wr; // clamped divider code
  // codes above nine clamp to nine
  assign div_wr = (hwdata[pcrc_pkg::DIV_LSB +: 8] > pcrc_pkg::DIV_MAX_CODE) ?
    pcrc_pkg::DIV_MAX_CODE : hwdata[pcrc_pkg::DIV_LSB +: 8];
  // clock setup reset by power-on only, control by any reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      setup_reg <= pcrc_pkg::pcrc_setup_t'(pcrc_pkg::CLK_SETUP_RST[18:0]);
      wd_en_reg <= 2'h3;
    end else if (ce) begin
      if (act.loop_reset) begin
        setup_reg <= pcrc_pkg::pcrc_setup_t'(pcrc_pkg::CLK_SETUP_RST[18:0]);
      end else if (wr_pend_reg && hit(addr_reg, pcrc_pkg::CLK_SETUP_OFF)) begin
        setup_reg.div <= div_wr;
        setup_reg.mul <= hwdata[pcrc_pkg::MUL_LSB +: 8];
        setup_reg.vco_range <= hwdata[pcrc_pkg::VCO_RANGE_BIT];
        setup_reg.src <= hwdata[pcrc_pkg::SRC_LSB +: 2];
      end
      // watchdog and monitor control back to default
      if (act.module_reset) begin
        wd_en_reg <= 2'h3;
      end else if (wr_pend_reg && hit(addr_reg, pcrc_pkg::RST_CTRL_OFF)) begin
        wd_en_reg <= hwdata[1:0];
      end
    end
  end
  // ==========================================
  // clock ratio model and glitch free source switch
  logic [1:0] src_reg; // source now driving core
  logic [1:0] gap_reg; // dead cycles during change
  // stop core clock two cycles before new source
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      src_reg <= pcrc_pkg::SRC_RAW;
      gap_reg <= 2'h0;
      core_clock_en <= 1'b1;
    end else if (ce) begin
      if (gap_reg != 2'h0) begin
        gap_reg <= gap_reg - 2'h1;
        core_clock_en <= (gap_reg == 2'h1);
        if (gap_reg == 2'h1) begin
          src_reg <= setup_reg.src;
        end
      end else if (setup_reg.src != src_reg) begin
        gap_reg <= 2'h2;
        core_clock_en <= 1'b0;
      end else begin
        core_clock_en <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      loop_ratio_num <= 16'h0001;
      loop_ratio_den <= 8'h01;
      core_div_factor <= 3'h1;
      core_src_active <= pcrc_pkg::SRC_RAW;
    end else if (ce) begin
      loop_ratio_num <= {8'h00, setup_reg.mul} + 16'h0001;
      loop_ratio_den <= setup_reg.div + 8'h01;
      core_src_active <= src_reg;
      unique case (src_reg)
        pcrc_pkg::SRC_VCO: core_div_factor <= setup_reg.vco_range ? 3'h1 : 3'h2;
        pcrc_pkg::SRC_HALF: core_div_factor <= setup_reg.vco_range ? 3'h2 : 3'h4;
        default: core_div_factor <= 3'h0;
      endcase
    end
  end
  // ==========================================
  // assertions
  property p_por_drives;
    @(posedge clk) disable iff (!rst_b)
      (ce && !por_sync[1]) ##1 ce |=> (hard_reset_n_oe && loop_reset);
  endproperty
  a_por_drives: assert property (p_por_drives) else $error("power-on did not drive hard pin");
  property p_soft_no_drive;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_reg == pcrc_pkg::PCRC_SOFT) |=> (!ce || !hard_reset_n_oe);
  endproperty
  a_soft_no_drive: assert property (p_soft_no_drive) else $error("soft reset drove hard pin");
  property p_hard_drives;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_reg == pcrc_pkg::PCRC_HARD) |=> (!ce || (hard_reset_n_oe && module_reset && !loop_reset));
  endproperty
  a_hard_drives: assert property (p_hard_drives) else $error("hard reset did not drive pin");
  property p_wdog;
    @(posedge clk) disable iff (!rst_b)
      (ce && wd_req && state_reg == pcrc_pkg::PCRC_RUN && !por_req) |=> (state_reg == pcrc_pkg::PCRC_HARD);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog missed hard reset");
  property p_div;
    @(posedge clk) disable iff (!rst_b)
      ce |=> (!ce || setup_reg.div <= pcrc_pkg::DIV_MAX_CODE);
  endproperty
  a_div: assert property (p_div) else $error("divider code out of range");
  sequence s_change;
    ce && gap_reg == 2'h0 && setup_reg.src != src_reg;
  endsequence
  property p_gap;
    @(posedge clk) disable iff (!rst_b)
      s_change |=> !core_clock_en;
  endproperty
  a_gap: assert property (p_gap) else $error("core clock not gated on switch");
endmodule

// ==== pcrc_board_model.sv ====
// board reset circuitry and reference clock source model
`timescale 1ns/10ps
module pcrc_board_model #(
  parameter int POR_REF_CYC = 20
) (
  // clock and bench requests
  input wire logic clk,
  input wire logic por_req,
  input wire logic hard_req,
  // board pins
  output logic power_on_reset_n,
  output logic hard_drive_n,
  output logic reference_clock_in
);
  logic [7:0] ref_cnt; // reference rising edges seen while holding
  // ==========================================
  // power-up: pin starts asserted
  initial begin
    power_on_reset_n = 1'b0;
    reference_clock_in = 1'b0;
    ref_cnt = 8'h00;
  end
  // reference clock, one toggle per system clock
  always @(posedge clk) begin
    reference_clock_in <= ~reference_clock_in;
  end
  always @(posedge clk) begin
    if (por_req) begin // fresh power-on request
      power_on_reset_n <= 1'b0;
      ref_cnt <= 8'h00;
    end else if (!power_on_reset_n && !reference_clock_in) begin // rising edge next
      ref_cnt <= ref_cnt + 8'h01;
      if (ref_cnt == 8'(POR_REF_CYC)) power_on_reset_n <= 1'b1;
    end
  end
  // board pulls the open-drain pin low
  assign hard_drive_n = ~hard_req;
endmodule

// ==== tb_pcrc_top.sv ====
// self-checking bench for the clock and reset control block
`timescale 1ns/10ps
module tb_pcrc_top;
  // ==========================================
  // signals
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, core_src_active;
  logic hreadyout, hresp, pin_out, pin_oe, hard_pin, board_n, por_n, ref_clk;
  logic wdog = 1'b0, bmon = 1'b0, scan = 1'b0, por_req = 1'b0, hard_req = 1'b0;
  logic [7:0] cfg = 8'h5a, den, config_latched;
  logic [15:0] num;
  logic [2:0] cdiv;
  logic cen, cfg_s, loop_r, mod_r;
  int num_errors = 0, checks = 0;
  // 50 ns clock
  always #25 clk = ~clk;
  // wire level of the pull-up hard pin
  assign hard_pin = board_n & ~(pin_oe & ~pin_out);
  // ==========================================
  // instances
  pcrc_top pcrc_top_i (.clk(clk), .rst_b(rst_b), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .power_on_reset_n(por_n),
    .hard_reset_n_in(hard_pin), .hard_reset_n_out(pin_out), .hard_reset_n_oe(pin_oe),
    .wdog_expired(wdog), .bmon_expired(bmon), .scan_clamp_active(scan), .config_pins(cfg),
    .reference_clock_in(ref_clk), .loop_ratio_num(num), .loop_ratio_den(den),
    .core_div_factor(cdiv), .core_clock_en(cen), .core_src_active(core_src_active),
    .config_sample(cfg_s), .loop_reset(loop_r), .module_reset(mod_r),
    .config_latched(config_latched));
  pcrc_board_model pcrc_board_model_i (.clk(clk), .por_req(por_req), .hard_req(hard_req),
    .power_on_reset_n(por_n), .hard_drive_n(board_n), .reference_clock_in(ref_clk));
  // ==========================================
  // verdict and comparison
  task report_and_stop();
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask
  // one bounded wait for ready, then give up
  task wait_rdy();
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) return;
    end
    num_errors++;
    report_and_stop();
  endtask
  // ==========================================
  // ahb-lite single word transfers
  task ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // wait until module reset reaches a level
  task wait_mod(input logic v);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (mod_r === v && (v || pin_oe === 1'b0)) return;
    end
    num_errors++;
    report_and_stop();
  endtask
  // ==========================================
  // scenario: state right after power-on
  task sc_power_on();
    wait_mod(1'b0);
    check("latched", {24'h0, config_latched}, {24'h0, cfg});
    ahb_xfer(1'b0, pcrc_pkg::RST_STATUS_OFF, 32'h0);
    check("status", rd, {27'h0, pcrc_pkg::RST_STATUS_POR});
    ahb_xfer(1'b0, pcrc_pkg::CLK_SETUP_OFF, 32'h0);
    check("setup", rd, pcrc_pkg::CLK_SETUP_RST);
    ahb_xfer(1'b0, 12'h00c, 32'h0);
    check("unmapped", rd, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask
  // scenario: divider, multiplier, range and source table
  task sc_clock();
    logic [7:0] d[5] = '{8'h03, 8'h04, 8'h09, 8'h0f, 8'h05};
    logic [7:0] m[5] = '{8'h0a, 8'h13, 8'h27, 8'h34, 8'h1a};
    logic [1:0] s[5] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h0};
    logic r[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [2:0] f[5] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h0};
    logic [31:0] w;
    logic gap;
    int i, n;
    for (i = 0; i < 5; i++) begin
      w = (32'(s[i]) << pcrc_pkg::SRC_LSB) | (32'(r[i]) << pcrc_pkg::VCO_RANGE_BIT) |
          (32'(m[i]) << pcrc_pkg::MUL_LSB) | 32'(d[i]);
      ahb_xfer(1'b1, pcrc_pkg::CLK_SETUP_OFF, w);
      gap = 1'b0;
      for (n = 0; n < 20 && core_src_active !== s[i]; n++) begin
        @(posedge clk);
        if (cen === 1'b0) gap = 1'b1;
      end
      repeat (3) @(posedge clk);
      ahb_xfer(1'b0, pcrc_pkg::CLK_SETUP_OFF, 32'h0);
      if (d[i] <= 8'h09) check("readback", rd, w);
      check("den", {24'h0, den}, (d[i] > 8'h09) ? 32'h0a : 32'(d[i]) + 32'h1);
      check("num", {16'h0, num}, 32'(m[i]) + 32'h1);
      check("factor", {29'h0, cdiv}, {29'h0, f[i]});
      check("src", {30'h0, core_src_active}, {30'h0, s[i]});
      check("en", {31'h0, cen}, 32'h1);
      if (i == 2) check("gap", {31'h0, gap}, 32'h1);
    end
  endtask
  // shared reset-source scenario: 0 wdog, 1 bmon, 2 scan, 3 hard pin
  task run_src(input int k, input logic hard, input logic [4:0] bit_exp);
    logic [31:0] keep;
    ahb_xfer(1'b0, pcrc_pkg::CLK_SETUP_OFF, 32'h0);
    keep = rd;
    @(posedge clk);
    wdog <= (k == 0);
    bmon <= (k == 1);
    scan <= (k == 2);
    hard_req <= (k == 3);
    wait_mod(1'b1);
    @(posedge clk);
    check("oe", {31'h0, pin_oe}, {31'h0, hard});
    check("pinout", {31'h0, pin_oe & pin_out}, 32'h0);
    check("loop", {31'h0, loop_r | cfg_s}, 32'h0);
    {wdog, bmon, scan, hard_req} <= 4'h0;
    wait_mod(1'b0);
    ahb_xfer(1'b0, pcrc_pkg::RST_STATUS_OFF, 32'h0);
    check("status", rd, {27'h0, bit_exp});
    ahb_xfer(1'b0, pcrc_pkg::CLK_SETUP_OFF, 32'h0);
    check("kept", rd, keep);
    ahb_xfer(1'b0, pcrc_pkg::RST_CTRL_OFF, 32'h0);
    check("ctrl", rd, 32'h3);
  endtask
  // scenario: disabled monitors are ignored
  task sc_disabled();
    ahb_xfer(1'b1, pcrc_pkg::RST_CTRL_OFF, 32'h0);
    @(posedge clk);
    {wdog, bmon} <= 2'h3;
    repeat (8) @(posedge clk);
    check("ignored", {31'h0, mod_r | pin_oe}, 32'h0);
    {wdog, bmon} <= 2'h0;
  endtask
  // scenario: a second power-on during operation
  task sc_repower();
    @(posedge clk);
    cfg <= 8'ha5;
    por_req <= 1'b1;
    @(posedge clk);
    por_req <= 1'b0;
    wait_mod(1'b1);
    repeat (2) @(posedge clk);
    check("por acts", {29'h0, pin_oe, loop_r, cfg_s}, 32'h7);
    sc_power_on();
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    sc_power_on();
    sc_clock();
    sc_disabled();
    run_src(2, 1'b0, 5'h10);
    run_src(0, 1'b1, 5'h04);
    run_src(1, 1'b1, 5'h08);
    run_src(3, 1'b1, 5'h02);
    sc_repower();
    report_and_stop();
  end
endmodule
